// file: src/ccq_pkg.sv
// Shared constants and state layout of the comparator control block
package ccq_pkg;

    // ============================================================
    // Register map
    // ============================================================
    localparam int ADDR_W = 4; // Register address width
    localparam logic [3:0] ADDR_CSR = 4'h0; // Comparator control/status offset
    localparam logic [7:0] CSR_RESET = 8'h00; // Control bits after reset

    // Field positions inside the control/status register
    localparam int BIT_POWER_OFF = 7;
    localparam int BIT_BANDGAP_SEL = 6;
    localparam int BIT_RESULT = 5;
    localparam int BIT_EVENT_FLAG = 4;
    localparam int BIT_IRQ_EN = 3;
    localparam int BIT_MUX_EN = 2;
    localparam int BIT_EVSEL_HI = 1;
    localparam int BIT_EVSEL_LO = 0;

    // ============================================================
    // Analogue side
    // ============================================================
    localparam int LVL_W = 10; // Digitised level width
    localparam int NUM_CH = 11; // Multiplexed analogue channels
    localparam int SEL_W = 4; // Low channel select bits
    localparam logic [3:0] SEL_LAST = 4'hA; // Highest defined select code
    localparam logic [9:0] LVL_UNDEF = 10'h3FF; // Level used for undefined codes

    // Event selection codes
    typedef enum logic [1:0] {
        EV_TOGGLE = 2'b00,
        EV_RESERVED = 2'b01,
        EV_FALL = 2'b10,
        EV_RISE = 2'b11
    } ccq_evsel_t;

    // Control bits held by software
    typedef struct packed {
        logic power_off;
        logic bandgap_sel;
        logic event_flag;
        logic irq_en;
        logic mux_en;
        ccq_evsel_t evsel;
    } ccq_csr_t;

    // One synchroniser stage of all analogue levels
    typedef struct packed {
        logic [LVL_W-1:0] pos_pin;
        logic [LVL_W-1:0] neg_pin;
        logic [LVL_W-1:0] bandgap;
        logic [NUM_CH*LVL_W-1:0] chan;
    } ccq_levels_t;

    // Complete block state
    typedef struct packed {
        ccq_levels_t lv1;
        ccq_levels_t lv2;
        ccq_csr_t csr;
        logic [SEL_W-1:0] sel;
        logic cmp;
        logic prev;
        logic [7:0] rdata;
    } ccq_state_t;

endpackage

// file: src/ccq_comparator_ctrl.sv
// Comparator control, event detection and interrupt logic
`timescale 1ns/10ps

// Operation
// R01: Result high when positive exceeds selected negative
// R02: Power-off bit seven switches comparator off
// R03: Software drops irq enable before power change
// R04: Bit six routes bandgap to positive input
// R05: Result bit five read-only, shows comparator
// R06: Matching output change sets event flag
// R07: Interrupt needs flag, enable, global enable
// R08: Vector entry clears event flag
// R09: Writing one clears flag; zero keeps
// R10: Bit three enables or blocks interrupt
// R11: Mux enable without converter selects channel
// R12: Codes zero to ten pick channels
// R13: Event select: toggle, reserved, fall, rise
// R14: Software drops irq enable before mode change
// R15: Top select bit ignored by comparator
// R16: Comparator on blocks both pin-change interrupts
// R17: New select takes effect one cycle later
// R18: Converter enable gates multiplexer mode
// R19: Sample output, edge from previous sample
module ccq_comparator_ctrl (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Register port
    input wire logic [ccq_pkg::ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Processor side
    input wire logic i_global_irq_en,
    input wire logic i_vector_ack,
    output logic o_irq,
    // Converter side
    input wire logic i_converter_enable,
    input wire logic [4:0] i_chan_sel,
    // Analogue levels, asynchronous to the clock
    input wire logic [ccq_pkg::LVL_W-1:0] i_pos_pin_level,
    input wire logic [ccq_pkg::LVL_W-1:0] i_neg_pin_level,
    input wire logic [ccq_pkg::LVL_W-1:0] i_bandgap_level,
    input wire logic [ccq_pkg::NUM_CH*ccq_pkg::LVL_W-1:0] i_chan_level,
    // Comparator status
    output logic o_result,
    output logic [1:0] o_pin_change_block
);

    // ============================================================
    // State
    // ============================================================
    ccq_pkg::ccq_state_t q; // Registered state
    ccq_pkg::ccq_state_t d; // Next state
    logic [ccq_pkg::LVL_W-1:0] pos_level; // Chosen positive level
    logic [ccq_pkg::LVL_W-1:0] neg_level; // Chosen negative level
    logic [ccq_pkg::LVL_W-1:0] chan_word [ccq_pkg::NUM_CH]; // Channel levels unpacked
    logic mux_mode; // Negative input from channel mux
    logic cmp_now; // Raw comparison this cycle
    logic event_now; // Qualifying output change
    logic csr_wr; // Write to the control register
    logic csr_rd; // Read of the control register

    // ============================================================
    // Elaboration checks
    // ============================================================
    // Decode assumes one channel per defined select code
    if (ccq_pkg::NUM_CH != int'(ccq_pkg::SEL_LAST) + 1)
    begin : g_chk_channels
        $error("channel count differs from defined select codes");
    end
    // The low select bits must reach every channel
    if (ccq_pkg::NUM_CH > (1 << ccq_pkg::SEL_W))
    begin : g_chk_sel_width
        $error("select field too narrow for channel count");
    end
    // Undefined codes rely on full scale to keep the result low
    if (ccq_pkg::LVL_UNDEF != {ccq_pkg::LVL_W{1'b1}})
    begin : g_chk_undef
        $error("undefined level must be full scale");
    end

    // ============================================================
    // Channel unpacking
    // ============================================================
    // One slice per channel of the synchronised level vector
    genvar gi;
    generate
        for (gi = 0; gi < ccq_pkg::NUM_CH; gi++)
        begin : g_chan
            assign chan_word[gi] = q.lv2.chan[gi*ccq_pkg::LVL_W +: ccq_pkg::LVL_W];
        end
    endgenerate

    // ============================================================
    // Input selection and comparison
    // ============================================================
    // Both inputs are picked from synchronised levels, except LVL_UNDEF for undefined codes
    always_comb
    begin
        // Mux mode only while the converter is off
        mux_mode = q.csr.mux_en && !i_converter_enable; // R11 R18
        // Positive side: pin or bandgap
        if (q.csr.bandgap_sel)
        begin
            pos_level = q.lv2.bandgap; // R04
        end
        else
        begin
            pos_level = q.lv2.pos_pin;
        end
        // Negative side: dedicated pin unless mux mode
        if (!mux_mode)
        begin
            neg_level = q.lv2.neg_pin; // R11
        end
        else if (q.sel <= ccq_pkg::SEL_LAST)
        begin
            // Delayed select, top bit never looked at
            neg_level = chan_word[q.sel]; // R12 R15 R17
        end
        else
        begin
            // Undefined codes: pick a level that keeps the result low
            neg_level = ccq_pkg::LVL_UNDEF; // R12
        end
        // Powered-off comparator reads as low
        cmp_now = !q.csr.power_off && (pos_level > neg_level); // R01 R02
    end

    // ============================================================
    // Event detection
    // ============================================================
    // Edge taken from the current and previous samples
    always_comb
    begin
        event_now = 1'b0;
        if (!q.csr.power_off)
        begin
            unique case (q.csr.evsel)
                ccq_pkg::EV_TOGGLE: event_now = q.cmp != q.prev; // R13 R19
                ccq_pkg::EV_RESERVED: event_now = 1'b0; // R13
                ccq_pkg::EV_FALL: event_now = !q.cmp && q.prev; // R13
                ccq_pkg::EV_RISE: event_now = q.cmp && !q.prev; // R13
            endcase
        end
    end

    // ============================================================
    // Next state
    // ============================================================
    // Register port decode, flag handling and sampling
    always_comb
    begin
        d = q;
        csr_wr = i_wr && (i_addr == ccq_pkg::ADDR_CSR);
        csr_rd = i_rd && (i_addr == ccq_pkg::ADDR_CSR);
        // Two-stage synchroniser, first stage feeds only the second
        d.lv1.pos_pin = i_pos_pin_level;
        d.lv1.neg_pin = i_neg_pin_level;
        d.lv1.bandgap = i_bandgap_level;
        d.lv1.chan = i_chan_level;
        d.lv2 = q.lv1;
        // Select code delayed by one cycle
        d.sel = i_chan_sel[ccq_pkg::SEL_W-1:0]; // R17 R15
        // Sample the comparison, keep the previous sample
        d.cmp = cmp_now; // R19
        d.prev = q.cmp; // R19
        // Software writes of the control bits; result bit ignored
        if (csr_wr)
        begin
            d.csr.power_off = i_wdata[ccq_pkg::BIT_POWER_OFF]; // R02
            d.csr.bandgap_sel = i_wdata[ccq_pkg::BIT_BANDGAP_SEL];
            d.csr.irq_en = i_wdata[ccq_pkg::BIT_IRQ_EN]; // R10
            d.csr.mux_en = i_wdata[ccq_pkg::BIT_MUX_EN];
            d.csr.evsel = ccq_pkg::ccq_evsel_t'(
                {i_wdata[ccq_pkg::BIT_EVSEL_HI], i_wdata[ccq_pkg::BIT_EVSEL_LO]});
            // Write one clears, write zero keeps
            if (i_wdata[ccq_pkg::BIT_EVENT_FLAG])
            begin
                d.csr.event_flag = 1'b0; // R09
            end
        end
        // Vector entry clears as well
        if (i_vector_ack)
        begin
            d.csr.event_flag = 1'b0; // R08
        end
        // A new event wins over any clear in the same cycle
        if (event_now)
        begin
            d.csr.event_flag = 1'b1; // R06
        end
        // Read data valid the cycle after the strobe only
        d.rdata = 8'h00;
        if (csr_rd)
        begin
            d.rdata[ccq_pkg::BIT_POWER_OFF] = q.csr.power_off;
            d.rdata[ccq_pkg::BIT_BANDGAP_SEL] = q.csr.bandgap_sel;
            d.rdata[ccq_pkg::BIT_RESULT] = q.cmp; // R05
            d.rdata[ccq_pkg::BIT_EVENT_FLAG] = q.csr.event_flag;
            d.rdata[ccq_pkg::BIT_IRQ_EN] = q.csr.irq_en;
            d.rdata[ccq_pkg::BIT_MUX_EN] = q.csr.mux_en;
            d.rdata[ccq_pkg::BIT_EVSEL_HI] = q.csr.evsel[1];
            d.rdata[ccq_pkg::BIT_EVSEL_LO] = q.csr.evsel[0];
        end
    end

    // ============================================================
    // State register
    // ============================================================
    // Asynchronous reset to constants only
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            q <= '0;
            // Control bits taken field by field from the register reset value
            q.csr.power_off <= ccq_pkg::CSR_RESET[ccq_pkg::BIT_POWER_OFF];
            q.csr.bandgap_sel <= ccq_pkg::CSR_RESET[ccq_pkg::BIT_BANDGAP_SEL];
            q.csr.event_flag <= ccq_pkg::CSR_RESET[ccq_pkg::BIT_EVENT_FLAG];
            q.csr.irq_en <= ccq_pkg::CSR_RESET[ccq_pkg::BIT_IRQ_EN];
            q.csr.mux_en <= ccq_pkg::CSR_RESET[ccq_pkg::BIT_MUX_EN];
            q.csr.evsel <= ccq_pkg::ccq_evsel_t'({ccq_pkg::CSR_RESET[ccq_pkg::BIT_EVSEL_HI],
                ccq_pkg::CSR_RESET[ccq_pkg::BIT_EVSEL_LO]});
        end
        else
        begin
            q <= d;
        end
    end

    // ============================================================
    // Outputs
    // ============================================================
    assign o_rdata = q.rdata;
    assign o_result = q.cmp; // R05
    // Level interrupt gated by enable and global enable
    assign o_irq = q.csr.event_flag && q.csr.irq_en && i_global_irq_en; // R07 R10
    // Pin-change interrupts blocked whenever the comparator runs
    assign o_pin_change_block = {2{!q.csr.power_off}}; // R16

    // ============================================================
    // Assertions
    // ============================================================
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    property p_result;
        !q.csr.power_off && (pos_level > neg_level) |=> o_result;
    endproperty
    a_result: assert property (p_result) else $error("result not high"); // R01

    property p_power_off;
        q.csr.power_off [*2] |-> !o_result && !event_now;
    endproperty
    a_power_off: assert property (p_power_off) else $error("off comparator active"); // R02

    property p_bandgap;
        q.csr.bandgap_sel |-> pos_level == q.lv2.bandgap;
    endproperty
    a_bandgap: assert property (p_bandgap) else $error("bandgap not routed"); // R04

    property p_read_result;
        csr_rd |=> o_rdata[ccq_pkg::BIT_RESULT] == $past(o_result)
            && o_rdata[ccq_pkg::BIT_BANDGAP_SEL] == $past(q.csr.bandgap_sel);
    endproperty
    a_read_result: assert property (p_read_result) else $error("read result wrong"); // R05

    property p_rise;
        q.csr.evsel == ccq_pkg::EV_RISE && !q.csr.power_off && q.cmp && !q.prev
            |=> q.csr.event_flag;
    endproperty
    a_rise: assert property (p_rise) else $error("rise event lost"); // R06 R13

    property p_no_reserved;
        q.csr.evsel == ccq_pkg::EV_RESERVED && !q.csr.event_flag
            |=> !q.csr.event_flag;
    endproperty
    a_no_reserved: assert property (p_no_reserved) else $error("reserved mode event"); // R13

    property p_irq;
        o_irq == (q.csr.event_flag && q.csr.irq_en && i_global_irq_en);
    endproperty
    a_irq: assert property (p_irq) else $error("irq gating wrong"); // R07 R10

    property p_ack;
        i_vector_ack && !event_now |=> !q.csr.event_flag;
    endproperty
    a_ack: assert property (p_ack) else $error("flag kept after vector"); // R08

    property p_w1c;
        csr_wr && !i_vector_ack && !event_now && q.csr.event_flag
            |=> q.csr.event_flag == !$past(i_wdata[ccq_pkg::BIT_EVENT_FLAG]);
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag write wrong"); // R09

    property p_pin_neg;
        !(q.csr.mux_en && !i_converter_enable) |-> neg_level == q.lv2.neg_pin;
    endproperty
    a_pin_neg: assert property (p_pin_neg) else $error("negative pin not used"); // R11 R18

    property p_sel_delay;
        ##1 mux_mode && $past(i_chan_sel[3:0]) <= ccq_pkg::SEL_LAST
            |-> neg_level == chan_word[$past(i_chan_sel[3:0])];
    endproperty
    a_sel_delay: assert property (p_sel_delay) else $error("select delay wrong"); // R12 R17

    property p_pin_block;
        !q.csr.power_off |-> o_pin_change_block == 2'b11;
    endproperty
    a_pin_block: assert property (p_pin_block) else $error("pin change not blocked"); // R16

    // An event must survive a clear that lands in the same cycle
    property p_set_wins;
        event_now |=> q.csr.event_flag;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost to clear"); // R06

    // Fall mode must flag a falling sample pair
    property p_fall;
        q.csr.evsel == ccq_pkg::EV_FALL && !q.csr.power_off && !q.cmp && q.prev
            |=> q.csr.event_flag;
    endproperty
    a_fall: assert property (p_fall) else $error("fall event lost"); // R06 R13

    // Toggle mode must flag either direction
    property p_toggle;
        q.csr.evsel == ccq_pkg::EV_TOGGLE && !q.csr.power_off && (q.cmp != q.prev)
            |=> q.csr.event_flag;
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle event lost"); // R13 R19

    // Rise mode must ignore a falling change
    property p_rise_only;
        q.csr.evsel == ccq_pkg::EV_RISE && !q.csr.event_flag && !(q.cmp && !q.prev)
            |=> !q.csr.event_flag;
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("rise mode took other edge"); // R13

    // Fall mode must ignore a rising change
    property p_fall_only;
        q.csr.evsel == ccq_pkg::EV_FALL && !q.csr.event_flag && !(!q.cmp && q.prev)
            |=> !q.csr.event_flag;
    endproperty
    a_fall_only: assert property (p_fall_only) else $error("fall mode took other edge"); // R13

    // Undefined codes must not borrow a real channel
    property p_undef_sel;
        mux_mode && (q.sel > ccq_pkg::SEL_LAST) |-> neg_level == ccq_pkg::LVL_UNDEF;
    endproperty
    a_undef_sel: assert property (p_undef_sel) else $error("undefined code used"); // R12

    // No lead on the positive side means a low result
    property p_result_low;
        !(pos_level > neg_level) |=> !o_result;
    endproperty
    a_result_low: assert property (p_result_low) else $error("result not low"); // R01

    // Without event, vector entry or a written one, the flag holds
    property p_flag_hold;
        !event_now && !i_vector_ack && !(csr_wr && i_wdata[ccq_pkg::BIT_EVENT_FLAG])
            |=> $stable(q.csr.event_flag);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag changed without cause"); // R09

    // Interrupt only rises after an event, an enable write or the global enable
    property p_irq_cause;
        $rose(o_irq) |-> $past(event_now) || $past(csr_wr) || $rose(i_global_irq_en);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq rose unprompted"); // R07 R10

    c_rise_flag: cover property (q.cmp && !q.prev ##1 q.csr.event_flag);
    c_irq: cover property (!o_irq ##1 o_irq);
    c_mux: cover property (mux_mode && q.sel == ccq_pkg::SEL_LAST);
    c_fall: cover property (q.csr.evsel == ccq_pkg::EV_FALL && event_now);
    c_undef: cover property (mux_mode && q.sel > ccq_pkg::SEL_LAST);

endmodule

// file: tb/ccq_analog_model.sv
// Analogue far side: pin levels, bandgap reference and channel levels
`timescale 1ns/10ps

// ============================================================
// Analogue source model
// ============================================================
module ccq_analog_model #(
    parameter logic [9:0] BANDGAP_LVL = 10'h0200, // Stand-in for the reference level
    parameter logic [9:0] CH_STEP = 10'h0050 // Spacing between channel levels
) (
    // Levels requested by the bench
    input wire logic [9:0] i_pos_set,
    input wire logic [9:0] i_neg_set,
    // Levels seen by the block
    output logic [9:0] o_pos_pin_level,
    output logic [9:0] o_neg_pin_level,
    output logic [9:0] o_bandgap_level,
    output logic [ccq_pkg::NUM_CH*10-1:0] o_chan_level
);
    // Pins follow the bench directly
    assign o_pos_pin_level = i_pos_set;
    assign o_neg_pin_level = i_neg_set;
    // Fixed reference, never changes at run time
    assign o_bandgap_level = BANDGAP_LVL;
    // Channel n rises with n, so a wrong pick shows as a wrong result
    for (genvar n = 0; n < ccq_pkg::NUM_CH; n++)
    begin : g_ch
        assign o_chan_level[10*n +: 10] = CH_STEP * 10'(n + 1);
    end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the comparator control block
`timescale 1ns/10ps

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("[FAIL] %0t got %h want %h", $time, got, exp); end end

module tb_top;
    // ============================================================
    // Signals
    // ============================================================
    logic i_ref_clk = 0;
    logic i_rst_n = 0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 0;
    logic i_rd = 0;
    logic [7:0] o_rdata;
    logic i_global_irq_en = 0;
    logic i_vector_ack = 0;
    logic o_irq;
    logic i_converter_enable = 0;
    logic [4:0] i_chan_sel = 5'h00;
    logic [9:0] pos_set = 10'h000; // Requested positive pin level
    logic [9:0] neg_set = 10'h000; // Requested negative pin level
    logic [9:0] pos_lvl, neg_lvl, bg_lvl;
    logic [109:0] chan_lvl;
    logic o_result;
    logic [1:0] o_pin_change_block;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [7:0] rv;

    // ============================================================
    // Clock, timeout, instances
    // ============================================================
    initial
    begin
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    // Ceiling well above the roughly 300 cycles the tests need
    always @(posedge i_ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            end_sim();
        end
    end

    ccq_analog_model u_ana (.i_pos_set(pos_set), .i_neg_set(neg_set),
        .o_pos_pin_level(pos_lvl), .o_neg_pin_level(neg_lvl),
        .o_bandgap_level(bg_lvl), .o_chan_level(chan_lvl));

    ccq_comparator_ctrl dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_global_irq_en(i_global_irq_en), .i_vector_ack(i_vector_ack), .o_irq(o_irq),
        .i_converter_enable(i_converter_enable), .i_chan_sel(i_chan_sel),
        .i_pos_pin_level(pos_lvl), .i_neg_pin_level(neg_lvl), .i_bandgap_level(bg_lvl),
        .i_chan_level(chan_lvl), .o_result(o_result),
        .o_pin_change_block(o_pin_change_block));

    // ============================================================
    // Bus and helper tasks
    // ============================================================
    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    // Set pin levels, then let sync, compare and flag stages settle
    task automatic lv(input logic [9:0] p, input logic [9:0] n);
        @(posedge i_ref_clk);
        pos_set <= p;
        neg_set <= n;
        repeat (6) @(posedge i_ref_clk);
        #1;
    endtask

    // Verdict and end of run
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ============================================================
    // Main sequence
    // ============================================================
    initial
    begin
        repeat (3) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        rd(4'h0, rv); `CHK(rv, 8'h00)
        `CHK(o_pin_change_block, 2'b11)
        // Unmapped place reads zero and ignores writes
        wr(4'h3, 8'hFF);
        rd(4'h3, rv); `CHK(rv, 8'h00)
        rd(4'h0, rv); `CHK(rv, 8'h00)
        // Result follows the inputs, toggle mode flags the rise
        lv(10'h200, 10'h100); `CHK(o_result, 1'b1)
        rd(4'h0, rv); `CHK(rv, 8'h30)
        wr(4'h0, 8'h20); // Result bit write and flag zero both ignored
        rd(4'h0, rv); `CHK(rv, 8'h30)
        wr(4'h0, 8'h10);
        rd(4'h0, rv); `CHK(rv, 8'h20)
        lv(10'h100, 10'h100); `CHK(o_result, 1'b0)
        // Every event mode, rise then fall; irq enable kept low while changing mode
        for (int m = 0; m < 4; m++)
        begin
            wr(4'h0, 8'h10 | 8'(m));
            lv(10'h200, 10'h100);
            rd(4'h0, rv); `CHK(rv, {3'b001, 1'(m == 0 || m == 3), 2'b00, 2'(m)})
            wr(4'h0, 8'h10 | 8'(m));
            lv(10'h100, 10'h200);
            rd(4'h0, rv); `CHK(rv, {3'b000, 1'(m == 0 || m == 2), 2'b00, 2'(m)})
        end
        // Interrupt needs flag, enable and global enable
        wr(4'h0, 8'h18);
        lv(10'h200, 10'h100); `CHK(o_irq, 1'b0)
        @(posedge i_ref_clk);
        i_global_irq_en <= 1'b1;
        @(posedge i_ref_clk);
        #1 `CHK(o_irq, 1'b1)
        @(posedge i_ref_clk);
        i_vector_ack <= 1'b1;
        @(posedge i_ref_clk);
        i_vector_ack <= 1'b0;
        #1 `CHK(o_irq, 1'b0)
        rd(4'h0, rv); `CHK(rv, 8'h28)
        lv(10'h100, 10'h200); `CHK(o_irq, 1'b1)
        wr(4'h0, 8'h00);
        #1 `CHK(o_irq, 1'b0)
        rd(4'h0, rv); `CHK(rv, 8'h10)
        // Bandgap replaces the positive pin
        wr(4'h0, 8'h50);
        lv(10'h000, 10'h100); `CHK(o_result, 1'b1)
        // Multiplexer mode, top select bit varied on purpose
        wr(4'h0, 8'h14);
        lv(10'h180, 10'h000);
        for (int c = 0; c < 16; c++)
        begin
            @(posedge i_ref_clk);
            i_chan_sel <= {1'(c), 4'(c)};
            repeat (6) @(posedge i_ref_clk);
            #1 `CHK(o_result, 1'(c <= 10 && 10'h180 > 10'h050 * 10'(c + 1)))
        end
        // Converter on returns the negative input to its pin
        @(posedge i_ref_clk);
        i_converter_enable <= 1'b1;
        repeat (6) @(posedge i_ref_clk);
        #1 `CHK(o_result, 1'b1)
        // Power off with the interrupt already disabled
        @(posedge i_ref_clk);
        i_converter_enable <= 1'b0;
        wr(4'h0, 8'h80);
        repeat (6) @(posedge i_ref_clk);
        #1 `CHK(o_result, 1'b0)
        `CHK(o_pin_change_block, 2'b00)
        // Reset in mid-run turns the comparator back on
        @(posedge i_ref_clk);
        i_rst_n <= 1'b0;
        #1 `CHK(o_pin_change_block, 2'b11)
        `CHK(o_irq, 1'b0)
        repeat (3) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        rd(4'h0, rv); `CHK(rv, 8'h00)
        end_sim();
    end
endmodule
